/* rtl/baud_tick_gen.v */
`default_nettype none
module baud_tick_gen #(
  parameter WIDTH = 16
) (
  // clock and reset
  input wire ref_clk_in,
  input wire reset_in,
  // divisor and tick
  input wire [WIDTH-1:0] divisor_in,
  output wire tick_out,
  output wire [WIDTH-1:0] count_out
);
  reg [WIDTH-1:0] count_ff;
  wire reload;
  wire [WIDTH-1:0] one_value;

  assign one_value = {{(WIDTH-1){1'b0}}, 1'b1};
  // a divisor of zero behaves as one
  assign reload = (count_ff <= one_value);
  assign tick_out = reload;
  assign count_out = count_ff;

  always @(posedge ref_clk_in)
  begin
    if (reset_in)
      count_ff <= one_value;
    else if (reload)
      count_ff <= divisor_in;
    else
      count_ff <= count_ff - one_value;
  end
endmodule // baud_tick_gen
`default_nettype wire

/* rtl/ir_decoder.v */
`default_nettype none
`include "ir_endec_defs.vh"
module ir_decoder (
  // clock and reset
  input wire ref_clk_in,
  input wire reset_in,
  // controls
  input wire tick_in,
  input wire ir_rx_in,
  // decoded stream
  output wire rx_data_out,
  output wire busy_out
);
  localparam ST_IDLE = 2'b01;
  localparam ST_TRACK = 2'b10;

  reg [1:0] state_ff;
  reg [3:0] count_ff;
  reg rx_prev_ff;
  reg rx_data_ff;
  reg seen_ff;
  reg window_ff;
  wire fall;

  // incoming pulse is high; its trailing falling edge resyncs the count
  assign fall = rx_prev_ff & ~ir_rx_in;
  assign rx_data_out = rx_data_ff;
  assign busy_out = state_ff[1];

  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      state_ff <= ST_IDLE;
      count_ff <= 4'h0;
      rx_prev_ff <= 1'b0;
      rx_data_ff <= 1'b1;
      seen_ff <= 1'b0;
      window_ff <= 1'b0;
    end
    else
    begin
      rx_prev_ff <= ir_rx_in;
      case (state_ff)
        ST_IDLE:
        begin
          if (fall)
          begin
            state_ff <= ST_TRACK;
            count_ff <= 4'h0;
            seen_ff <= 1'b1;
            window_ff <= 1'b0;
          end
        end
        ST_TRACK:
        begin
          if (fall && window_ff)
          begin
            count_ff <= 4'h0;
            seen_ff <= 1'b1;
          end
          else if (tick_in)
          begin
            count_ff <= count_ff + 4'h1;
            if (count_ff + 4'h1 == `DEC_UPDATE_COUNT)
            begin
              rx_data_ff <= ~seen_ff;
              if (!seen_ff)
              begin
                state_ff <= ST_IDLE;
                window_ff <= 1'b0;
              end
              else if (window_ff)
                window_ff <= 1'b0;
              seen_ff <= 1'b0;
            end
            if (count_ff + 4'h1 == `DEC_WINDOW_OPEN)
              window_ff <= 1'b1;
          end
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule // ir_decoder
`default_nettype wire

/* rtl/ir_endec_defs.vh */
`ifndef IR_ENDEC_DEFS_VH
`define IR_ENDEC_DEFS_VH
// register addresses
`define REG_DIV_HIGH 12'hf46
`define REG_DIV_LOW 12'hf47
`define REG_CONTROL 12'hf43
`define REG_STATUS 12'hf48
// control and status field positions
`define CTL_CODEC_EN 0
`define CTL_READ_COUNT 1
`define STS_RX_BUSY 0
`define STS_DECODED_RX 1
`define STS_TX_ACTIVE 2
// reset values
`define DIV_HIGH_RESET 8'h01
`define DIV_LOW_RESET 8'h01
// baud tick framing: encoder bit start and pulse placement, decoder update and window counts
`define ENC_BIT_START 4'h0
`define ENC_PULSE_START 4'h7
`define ENC_PULSE_END 4'h9
`define DEC_UPDATE_COUNT 4'h8
`define DEC_WINDOW_OPEN 4'hc
`endif

/* rtl/ir_endec_top.v */
// The implementer's own choice: the strobed register port.
`default_nettype none
`include "ir_endec_defs.vh"
module ir_endec_top (
  // clock and reset
  input wire ref_clk_in,
  input wire reset_in,
  // register port
  input wire [11:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_write_in,
  input wire reg_read_in,
  output wire [7:0] reg_rdata_out,
  // serial side
  input wire uart_txd_in,
  output wire uart_rxd_out,
  output wire baud_tick_out,
  // pins
  output wire infrared_tx_out,
  input wire infrared_rx_in
);
  reg [7:0] div_high_ff;
  reg [7:0] div_low_ff;
  reg codec_en_ff;
  reg read_count_ff;
  reg [7:0] rdata_ff;
  reg [7:0] nxt_rdata;
  reg [3:0] tx_phase_ff;
  reg tx_bit_ff;
  reg ir_tx_ff;
  reg [1:0] state_ff;
  wire [15:0] baud_divisor_value;
  wire [15:0] live_count;
  wire tick;
  wire dec_rx;
  wire dec_busy;
  wire dec_input;
  wire tx_active;

  localparam ST_IDLE = 2'b01;
  localparam ST_SEND = 2'b10;

  // --------------------------------------------------------------
  // divisor and tick
  // --------------------------------------------------------------
  // concatenate bytes
  assign baud_divisor_value = {div_high_ff, div_low_ff};

  baud_tick_gen #(
    .WIDTH(16)
  ) u_tick (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .divisor_in(baud_divisor_value),
    .tick_out(tick),
    .count_out(live_count)
  );
  assign baud_tick_out = tick;

  // --------------------------------------------------------------
  // encoder
  // --------------------------------------------------------------
  // transmit is active while the encoder is in ST_SEND
  assign tx_active = (state_ff == ST_SEND);

  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      state_ff <= ST_IDLE;
      tx_phase_ff <= 4'h0;
      tx_bit_ff <= 1'b1;
      ir_tx_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          ir_tx_ff <= 1'b0;
          // no transmit start while decoder busy
          if (codec_en_ff && tick && !uart_txd_in && !dec_busy)
          begin
            state_ff <= ST_SEND;
            tx_phase_ff <= 4'h1;
            tx_bit_ff <= 1'b0;
          end
        end
        ST_SEND:
        begin
          if (tick)
          begin
            tx_phase_ff <= tx_phase_ff + 4'h1;
            // next bit taken on the tick that opens it, never one tick early
            if (tx_phase_ff == `ENC_BIT_START)
            begin
              tx_bit_ff <= uart_txd_in;
              if (uart_txd_in)
                state_ff <= ST_IDLE;
            end
            // high for three ticks after seven low
            if (!tx_bit_ff && tx_phase_ff >= `ENC_PULSE_START
                && tx_phase_ff <= `ENC_PULSE_END)
              ir_tx_ff <= 1'b1;
            else
              ir_tx_ff <= 1'b0;
          end
          if (!codec_en_ff)
          begin
            state_ff <= ST_IDLE;
            ir_tx_ff <= 1'b0;
          end
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // decoder and path select
  // --------------------------------------------------------------
  // receive gated off while transmitting
  assign dec_input = codec_en_ff & ~tx_active & infrared_rx_in;

  // decoder keeps its own count only
  ir_decoder u_dec (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .tick_in(tick),
    .ir_rx_in(dec_input),
    .rx_data_out(dec_rx),
    .busy_out(dec_busy)
  );

  assign infrared_tx_out = codec_en_ff ? ir_tx_ff : uart_txd_in;
  assign uart_rxd_out = codec_en_ff ? dec_rx : infrared_rx_in;

  // --------------------------------------------------------------
  // register port
  // --------------------------------------------------------------
  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      div_high_ff <= `DIV_HIGH_RESET;
      div_low_ff <= `DIV_LOW_RESET;
      codec_en_ff <= 1'b0;
      read_count_ff <= 1'b0;
    end
    else if (reg_write_in)
    begin
      if (reg_addr_in == `REG_DIV_HIGH)
        div_high_ff <= reg_wdata_in;
      else if (reg_addr_in == `REG_DIV_LOW)
        div_low_ff <= reg_wdata_in;
      else if (reg_addr_in == `REG_CONTROL)
      begin
        codec_en_ff <= reg_wdata_in[`CTL_CODEC_EN];
        read_count_ff <= reg_wdata_in[`CTL_READ_COUNT];
      end
    end
  end

  always @*
  begin
    nxt_rdata = 8'h00;
    if (reg_addr_in == `REG_DIV_HIGH)
      nxt_rdata = read_count_ff ? live_count[15:8] : div_high_ff;
    else if (reg_addr_in == `REG_DIV_LOW)
      nxt_rdata = read_count_ff ? live_count[7:0] : div_low_ff;
    else if (reg_addr_in == `REG_CONTROL)
    begin
      nxt_rdata[`CTL_CODEC_EN] = codec_en_ff;
      nxt_rdata[`CTL_READ_COUNT] = read_count_ff;
    end
    else if (reg_addr_in == `REG_STATUS)
    begin
      nxt_rdata[`STS_RX_BUSY] = dec_busy;
      nxt_rdata[`STS_DECODED_RX] = dec_rx;
      nxt_rdata[`STS_TX_ACTIVE] = tx_active;
    end
  end

  always @(posedge ref_clk_in)
  begin
    if (reset_in)
      rdata_ff <= 8'h00;
    else if (reg_read_in)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= 8'h00;
  end
  assign reg_rdata_out = rdata_ff;
endmodule // ir_endec_top
`default_nettype wire

/* verif/ir_endec_checker.sv */
`default_nettype none
`include "ir_endec_defs.vh"
module ir_endec_checker (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // register port
  input wire logic [11:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  // serial side and pins
  input wire logic uart_txd_in,
  input wire logic uart_rxd_out,
  input wire logic baud_tick_out,
  input wire logic infrared_tx_out,
  input wire logic infrared_rx_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic en_ff;
  logic rc_ff;
  logic [15:0] div_ff;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // ----
  // shadow of enable, read-count select and divisor
  // ----
  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      en_ff <= 1'b0;
      rc_ff <= 1'b0;
      div_ff <= {`DIV_HIGH_RESET, `DIV_LOW_RESET};
    end
    else if (reg_write_in)
    begin
      if (reg_addr_in == `REG_CONTROL) en_ff <= reg_wdata_in[0];
      if (reg_addr_in == `REG_CONTROL) rc_ff <= reg_wdata_in[1];
      if (reg_addr_in == `REG_DIV_HIGH) div_ff[15:8] <= reg_wdata_in;
      if (reg_addr_in == `REG_DIV_LOW) div_ff[7:0] <= reg_wdata_in;
    end
  end
  sequence s_rd(logic [11:0] a);
    // stored divisor reads only, not live count
    reg_read_in && reg_addr_in == a && !rc_ff;
  endsequence
  sequence s_zero_pulse;
    infrared_tx_out [*6] ##1 !infrared_tx_out;
  endsequence
  a_rdata_idle: assert property (!reg_read_in |=> reg_rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  a_rdata_unmapped: assert property (
    reg_read_in && !(reg_addr_in inside {`REG_CONTROL, `REG_DIV_HIGH, `REG_DIV_LOW,
    `REG_STATUS}) |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_div_high: assert property (s_rd(`REG_DIV_HIGH) |=> reg_rdata_out == div_ff[15:8])
    else $error("divisor high byte wrong");
  a_div_low: assert property (s_rd(`REG_DIV_LOW) |=> reg_rdata_out == div_ff[7:0])
    else $error("divisor low byte wrong");
  a_bypass_tx: assert property (!en_ff |-> infrared_tx_out == uart_txd_in)
    else $error("tx pin not bypassed");
  a_bypass_rx: assert property (!en_ff |-> uart_rxd_out == infrared_rx_in)
    else $error("rx not bypassed");
  a_tick_period: assert property (
    baud_tick_out && div_ff == 16'h0002 |=> !baud_tick_out ##1 baud_tick_out)
    else $error("tick spacing wrong");
  a_pulse_width: assert property (
    en_ff && div_ff == 16'h0002 && $rose(infrared_tx_out) |-> s_zero_pulse)
    else $error("tx pulse width wrong");
endmodule // ir_endec_checker
bind ir_endec_top ir_endec_checker i_chk (.ref_clk_in, .reset_in, .reg_addr_in,
  .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .uart_txd_in, .uart_rxd_out,
  .baud_tick_out, .infrared_tx_out, .infrared_rx_in);
`default_nettype wire

/* verif/ir_transceiver_model.sv */
`default_nettype none
module ir_transceiver_model (
  // clock, reset, tick
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic tick_in,
  // optical side
  input wire logic ir_tx_in,
  output logic ir_rx_out = 1'b0,
  output logic [7:0] pulse_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tx_q = 1'b0;
  logic tk = 1'b0;
  always @(negedge ref_clk_in) tk = tick_in;
  // ----
  // transmit pulse counter
  // ----
  always @(posedge ref_clk_in)
  begin
    tx_q <= ir_tx_in;
    if (reset_in) pulse_count <= 8'h00;
    else if (ir_tx_in && !tx_q) pulse_count <= pulse_count + 8'h01;
  end
  task automatic send_frame(input logic [9:0] f);
    for (int i = 0; i < 10; i++)
      for (int p = 0; p < 16; p++)
      begin
        @(posedge ref_clk_in iff tk);
        ir_rx_out <= !f[i] && p >= 7 && p <= 9;
      end
  endtask
endmodule // ir_transceiver_model
`default_nettype wire

/* verif/test_infrared_endec_baud_divisor.sv */
`default_nettype none
`include "ir_endec_defs.vh"
module test_infrared_endec_baud_divisor;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [11:0] reg_addr_in = 12'h000;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_write_in = 1'b0;
  logic reg_read_in = 1'b0;
  logic uart_txd_in = 1'b1;
  logic byp_sel = 1'b1;
  logic byp_rx = 1'b0;
  logic rd_seen = 1'b0;
  logic tk = 1'b0;
  logic [7:0] exp_q[$];
  wire [7:0] reg_rdata_out;
  wire [7:0] pulse_count;
  wire uart_rxd_out, baud_tick_out, infrared_tx_out, model_rx;
  wire infrared_rx_in = byp_sel ? byp_rx : model_rx;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  integer seed = 32'hfd44_d4c6;
  ir_endec_top i_dut (.ref_clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
    .reg_read_in, .reg_rdata_out, .uart_txd_in, .uart_rxd_out, .baud_tick_out,
    .infrared_tx_out, .infrared_rx_in);
  ir_transceiver_model i_ir (.ref_clk_in, .reset_in, .tick_in(baud_tick_out),
    .ir_tx_in(infrared_tx_out), .ir_rx_out(model_rx), .pulse_count);
  initial forever #10 ref_clk_in = ~ref_clk_in;
  always @(negedge ref_clk_in) tk = baud_tick_out;
  // ----
  // bus tasks and comparison
  // ----
  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [7:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= w;
    reg_read_in <= r;
    if (r) exp_q.push_back(d);
    @(posedge ref_clk_in);
  endtask
  task automatic tick_wait(input int n);
    repeat (n) @(posedge ref_clk_in iff tk);
  endtask
  always @(posedge ref_clk_in) rd_seen <= reg_read_in;
  always @(negedge ref_clk_in)
    if (rd_seen) chk("reg_rdata_out", exp_q.pop_front(), reg_rdata_out);
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      failures++;
      report_and_stop();
    end
  end
  // ----
  // main sequence
  // ----
  initial
  begin
    logic [7:0] d;
    logic [7:0] pc;
    logic [9:0] f;
    repeat (20) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    bus(0, 1, `REG_DIV_HIGH, `DIV_HIGH_RESET);
    bus(0, 1, `REG_DIV_LOW, `DIV_LOW_RESET);
    bus(0, 1, 12'h0f40, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($random(seed));
      bus(1, 0, `REG_DIV_HIGH + 12'(i % 2), d);
      bus(0, 1, `REG_DIV_HIGH + 12'(i % 2), d);
    end
    bus(1, 0, `REG_DIV_HIGH, 8'h00);
    bus(1, 0, `REG_DIV_LOW, 8'h02);
    bus(0, 0, 12'h000, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      d = 8'($random(seed));
      uart_txd_in <= d[0];
      byp_rx <= d[1];
      @(negedge ref_clk_in);
      chk("infrared_tx_out", {7'h00, d[0]}, {7'h00, infrared_tx_out});
      chk("uart_rxd_out", {7'h00, d[1]}, {7'h00, uart_rxd_out});
      @(posedge ref_clk_in);
    end
    uart_txd_in <= 1'b1;
    byp_rx <= 1'b0;
    bus(1, 0, `REG_CONTROL, 8'h03);
    byp_sel <= 1'b0;
    bus(0, 1, `REG_CONTROL, 8'h03);
    bus(0, 1, `REG_STATUS, 8'h02);
    bus(0, 0, 12'h000, 8'h00);
    tick_wait(1);
    bus(0, 1, `REG_DIV_LOW, 8'h02);
    bus(0, 1, `REG_DIV_LOW, 8'h01);
    bus(0, 1, `REG_DIV_HIGH, 8'h00);
    bus(1, 0, `REG_CONTROL, 8'h01);
    bus(0, 0, 12'h000, 8'h00);
    for (int j = 0; j < 2; j++)
    begin
      d = j ? 8'h00 : 8'($random(seed));
      f = {1'b1, d, 1'b0};
      pc = pulse_count;
      tick_wait(1);
      for (int i = 0; i < 10; i++)
      begin
        @(posedge ref_clk_in);
        uart_txd_in <= f[i];
        tick_wait(16);
      end
      tick_wait(40);
      chk("pulse_count", 8'($countones(~f)), pulse_count - pc);
      fork
        i_ir.send_frame(f);
        begin
          tick_wait(26);
          for (int k = 0; k < 10; k++)
          begin
            @(negedge ref_clk_in);
            chk("uart_rxd_out", {7'h00, f[k]}, {7'h00, uart_rxd_out});
            tick_wait(16);
          end
        end
      join
      tick_wait(40);
    end
    report_and_stop();
  end
endmodule // test_infrared_endec_baud_divisor
`default_nettype wire
